// ==== logic/bst_pkg.sv ====
// ==========================================================
// Boundary-scan constants and state layouts
package bst_pkg;
   // Register widths
   localparam int ID_W  = 32;
   localparam int IR_W  = 3;
   localparam int BSR_W = 98;
   // Instruction codes and capture pattern
   localparam logic [IR_W-1:0] IR_EXTEST  = 3'h0;
   localparam logic [IR_W-1:0] IR_SAMPLE  = 3'h4;
   localparam logic [IR_W-1:0] IR_IDCODE  = 3'h6;
   localparam logic [IR_W-1:0] IR_BYPASS  = 3'h7;
   localparam logic [IR_W-1:0] IR_CAPTURE = 3'h4;
   // Identity word fields
   localparam int ID_ONE_POS  = 0;
   localparam int ID_PROD_LSB = 1;
   localparam int ID_PROD_W   = 11;
   localparam int ID_PART_LSB = 12;
   localparam int ID_PART_W   = 16;
   localparam int ID_REV_LSB  = 28;
   localparam int ID_REV_W    = 4;

   // ==========================================================
   // Controller states, one-hot
   typedef enum logic [15:0] {
      ST_TLR    = 16'h0001,
      ST_IDLE   = 16'h0002,
      ST_SEL_DR = 16'h0004,
      ST_CAP_DR = 16'h0008,
      ST_SH_DR  = 16'h0010,
      ST_EX1_DR = 16'h0020,
      ST_PAU_DR = 16'h0040,
      ST_EX2_DR = 16'h0080,
      ST_UPD_DR = 16'h0100,
      ST_SEL_IR = 16'h0200,
      ST_CAP_IR = 16'h0400,
      ST_SH_IR  = 16'h0800,
      ST_EX1_IR = 16'h1000,
      ST_PAU_IR = 16'h2000,
      ST_EX2_IR = 16'h4000,
      ST_UPD_IR = 16'h8000
   } bst_state_t;

   // ==========================================================
   // Per-domain state records and reset values
   typedef struct packed {
      bst_state_t st;
   } bst_fsm_t;
   typedef struct packed {
      logic [IR_W-1:0]  ir_sh;
      logic [ID_W-1:0]  id_sh;
      logic             byp;
      logic [BSR_W-1:0] bsr_sh;
   } bst_tr_t;
   typedef struct packed {
      logic [IR_W-1:0]  ir_cur;
      logic [BSR_W-1:0] bsr_lat;
      logic             ext_on;
      logic             upd_tgl;
      logic             tdo;
      logic             tdo_oe;
   } bst_tf_t;
   typedef struct packed {
      logic             tap_rst_req;
      logic             tgl_seen;
      logic [BSR_W-1:0] lat_copy;
      logic [BSR_W-1:0] pin_out;
      logic             test_mode;
   } bst_sys_t;
   localparam bst_fsm_t FSM_RST = '{st: ST_TLR};
   localparam bst_tr_t  TR_RST  = '0;
   localparam bst_tf_t  TF_RST  = '{ir_cur: IR_IDCODE, bsr_lat: '0, default: 1'b0};
   localparam bst_sys_t SYS_RST = '{tap_rst_req: 1'b1, lat_copy: '0, pin_out: '0, default: 1'b0};

   // ==========================================================
   // Data register decode
   function automatic logic scan_sel(input logic [IR_W-1:0] ir);
      scan_sel = (ir == IR_EXTEST) || (ir == IR_SAMPLE);
   endfunction
   function automatic logic id_sel(input logic [IR_W-1:0] ir);
      id_sel = (ir == IR_IDCODE);
   endfunction
endpackage

// ==== logic/bst_tap_if.sv ====
`timescale 1ns/1ps
// ==========================================================
// Controller link between data path and state machine
interface bst_tap_if;
   logic                tms;
   bst_pkg::bst_state_t state;
   modport ctrl (input tms, output state);
   modport user (output tms, input state);
endinterface

// ==== logic/bst_sync.sv ====
`timescale 1ns/1ps
// ==========================================================
// Three-stage input filter, output follows once stages 2 and 3 agree
module bst_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         en,
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] o;
   } bst_sync_t;
   bst_sync_t sy_ff;
   bst_sync_t nxt_sy;

   // Stage 1 feeds stage 2 only; per-bit agreement filter
   always_comb begin
      nxt_sy = sy_ff;
      if (en) begin
         nxt_sy.s1 = d;
         nxt_sy.s2 = sy_ff.s1;
         nxt_sy.s3 = sy_ff.s2;
         nxt_sy.o  = (sy_ff.s3 & ~(sy_ff.s2 ^ sy_ff.s3)) | (sy_ff.o & (sy_ff.s2 ^ sy_ff.s3));
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sy_ff <= '0;
      end else begin
         sy_ff <= nxt_sy;
      end
   end

   assign q = sy_ff.o;
endmodule

// ==== logic/bst_tap_fsm.sv ====
`timescale 1ns/1ps
// ==========================================================
// Sixteen-state test access controller on the test clock
module bst_tap_fsm (
   input wire logic tck,
   input wire logic tck_rst,
   bst_tap_if.ctrl  tap
);
   bst_pkg::bst_fsm_t fsm_ff;
   bst_pkg::bst_fsm_t nxt_fsm;
   bst_pkg::bst_state_t st;

   always_comb begin
      nxt_fsm = fsm_ff;
      case (fsm_ff.st)
         bst_pkg::ST_TLR:    nxt_fsm.st = tap.tms ? bst_pkg::ST_TLR : bst_pkg::ST_IDLE;
         bst_pkg::ST_IDLE:   nxt_fsm.st = tap.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_DR: nxt_fsm.st = tap.tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
         bst_pkg::ST_CAP_DR: nxt_fsm.st = tap.tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_SH_DR:  nxt_fsm.st = tap.tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_EX1_DR: nxt_fsm.st = tap.tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
         bst_pkg::ST_PAU_DR: nxt_fsm.st = tap.tms ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
         bst_pkg::ST_EX2_DR: nxt_fsm.st = tap.tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_UPD_DR: nxt_fsm.st = tap.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_IR: nxt_fsm.st = tap.tms ? bst_pkg::ST_TLR : bst_pkg::ST_CAP_IR;
         bst_pkg::ST_CAP_IR: nxt_fsm.st = tap.tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_SH_IR:  nxt_fsm.st = tap.tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_EX1_IR: nxt_fsm.st = tap.tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
         bst_pkg::ST_PAU_IR: nxt_fsm.st = tap.tms ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
         bst_pkg::ST_EX2_IR: nxt_fsm.st = tap.tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_UPD_IR: nxt_fsm.st = tap.tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         default:            nxt_fsm.st = bst_pkg::ST_TLR;
      endcase
   end

   always_ff @(posedge tck or posedge tck_rst) begin
      if (tck_rst) begin
         fsm_ff <= bst_pkg::FSM_RST;
      end else begin
         fsm_ff <= nxt_fsm;
      end
   end

   assign st = fsm_ff.st;
   assign tap.state = fsm_ff.st;

   // ==========================================================
   // Checks
   default clocking cb @(posedge tck); endclocking
   default disable iff (tck_rst);
   sequence s_tms_high5;
      tap.tms [*5];
   endsequence
   AST_TMS_FIVE: assert property (s_tms_high5 |=> st == bst_pkg::ST_TLR)
      else $error("five high tms did not reach reset");
   AST_IDLE_HOLD: assert property (st == bst_pkg::ST_IDLE && !tap.tms |=> st == bst_pkg::ST_IDLE)
      else $error("idle left with tms low");
   AST_SEL_DR: assert property (st == bst_pkg::ST_SEL_DR |=> st == ($past(tap.tms) ? bst_pkg::ST_SEL_IR
                                                                                  : bst_pkg::ST_CAP_DR))
      else $error("bad exit from data select");
   AST_SHIFT_PATH: assert property (st == bst_pkg::ST_CAP_DR && !tap.tms ##1 !tap.tms [*2]
                                    |=> st == bst_pkg::ST_SH_DR)
      else $error("shift not held with tms low");
   AST_PAUSE_LOOP: assert property (st == bst_pkg::ST_EX1_DR && !tap.tms ##1 tap.tms ##1 !tap.tms
                                    |=> st == bst_pkg::ST_SH_DR)
      else $error("pause to exit2 to shift failed");
   AST_EXIT_UPD: assert property ((st == bst_pkg::ST_EX1_DR || st == bst_pkg::ST_EX2_DR) && tap.tms
                                  |=> st == bst_pkg::ST_UPD_DR)
      else $error("exit did not go to update");
   AST_SEL_IR: assert property (st == bst_pkg::ST_SEL_IR && tap.tms |=> st == bst_pkg::ST_TLR)
      else $error("ir select with tms high not reset");
   AST_UPD_IDLE: assert property (st == bst_pkg::ST_UPD_IR && !tap.tms |=> st == bst_pkg::ST_IDLE)
      else $error("update with tms low not idle");
endmodule

// ==== logic/bst_tap_top.sv ====
`timescale 1ns/1ps
// ==========================================================
// Operation
// - Identity register is 32 bits, shifted out low bit first.
// - Identity: bit 0 one, producer 1-11, part 12-27, revision 28-31.
// - Single-bit pass register gives a short path from input to output.
// - 98-bit pin chain used only by external test or sample/preload.
// - Controller has sixteen states, stepped by tms at rising edges.
// - Reset state disables test logic and selects identity instruction.
// - Five high tms edges reach reset; stays there while high.
// - Power-up enters reset state without any test clock edge.
// - Idle holds while tms low; high goes to data select.
// - Data select: low captures data, high goes to instruction select.
// - Capture loads pins only for chain instructions; then exit1 or shift.
// - Shift moves selected register toward output; high leaves to exit1.
// - Exit1: high goes to update, low goes to pause.
// - Pause freezes shifting while low; high goes to exit2.
// - Exit2: high goes to update, low returns to shift.
// - Chain output latch loads on falling edge in data update only.
// - Instruction select: low captures instruction, high goes to reset.
// - Other states keep instruction and unselected registers unchanged.
// - Three-bit instruction, low bit first; four listed codes decoded.
// - Instruction capture loads pattern 100, current instruction unchanged.
// - Instruction update latches shifted code on falling edge.
module bst_tap_top #(
   parameter logic [bst_pkg::ID_PROD_W-1:0] PRODUCER = 11'h155, // Arbitrary value
   parameter logic [bst_pkg::ID_PART_W-1:0] PART     = 16'h0a5c, // Arbitrary value
   parameter logic [bst_pkg::ID_REV_W-1:0]  REVISION = 4'h1     // Arbitrary value
) (
   input  wire logic                      mclk,
   input  wire logic                      rst,
   input  wire logic                      ce,
   input  wire logic                      tck,
   input  wire logic                      tms,
   input  wire logic                      tdi,
   output      logic                      tdo,
   output      logic                      tdo_oe,
   input  wire logic [bst_pkg::BSR_W-1:0] pin_in,
   input  wire logic [bst_pkg::BSR_W-1:0] core_pin_out,
   output      logic [bst_pkg::BSR_W-1:0] pin_out,
   output      logic                      test_mode
);
   bst_pkg::bst_sys_t sys_ff;
   bst_pkg::bst_sys_t nxt_sys;
   bst_pkg::bst_tr_t  tr_ff;
   bst_pkg::bst_tr_t  nxt_tr;
   bst_pkg::bst_tf_t  tf_ff;
   bst_pkg::bst_tf_t  nxt_tf;
   logic [1:0]                trst_ff;
   logic                      tck_rst;
   logic [bst_pkg::BSR_W-1:0] pin_sync;
   logic                      mode_sync;
   logic                      tgl_sync;
   logic                      dr_out;
   logic [bst_pkg::ID_W-1:0]  id_word;
   logic                      sh_dr;
   logic                      sh_ir;
   bst_tap_if                 tap ();

   // ==========================================================
   // Test clock domain reset
   // Asserts at once from the system side, releases on two test clock edges
   always_ff @(posedge tck or posedge sys_ff.tap_rst_req) begin
      if (sys_ff.tap_rst_req) begin
         trst_ff <= 2'h3;
      end else begin
         trst_ff <= {trst_ff[0], 1'b0};
      end
   end
   assign tck_rst = trst_ff[1];

   // ==========================================================
   // Controller and input filters
   assign tap.tms = tms;

   bst_tap_fsm u_fsm (
      .tck     (tck),
      .tck_rst (tck_rst),
      .tap     (tap)
   );

   // Pins are asynchronous to the test clock
   bst_sync #(
      .W (bst_pkg::BSR_W)
   ) u_pin_sync (
      .clk (tck),
      .rst (tck_rst),
      .en  (1'b1),
      .d   (pin_in),
      .q   (pin_sync)
   );

   // Mode level and update toggle into the system clock
   bst_sync #(
      .W (2)
   ) u_sys_sync (
      .clk (mclk),
      .rst (rst),
      .en  (ce),
      .d   ({tf_ff.ext_on, tf_ff.upd_tgl}),
      .q   ({mode_sync, tgl_sync})
   );

   // ==========================================================
   // Decode helpers
   assign sh_dr = (tap.state == bst_pkg::ST_SH_DR);
   assign sh_ir = (tap.state == bst_pkg::ST_SH_IR);

   always_comb begin
      id_word = '0;
      id_word[bst_pkg::ID_ONE_POS] = 1'b1;
      id_word[bst_pkg::ID_PROD_LSB +: bst_pkg::ID_PROD_W] = PRODUCER;
      id_word[bst_pkg::ID_PART_LSB +: bst_pkg::ID_PART_W] = PART;
      id_word[bst_pkg::ID_REV_LSB +: bst_pkg::ID_REV_W] = REVISION;
   end

   // Serial register choice
   // Unlisted codes fall to the pass bit, the safe choice for a chain
   always_comb begin
      if (bst_pkg::scan_sel(tf_ff.ir_cur)) begin
         dr_out = tr_ff.bsr_sh[0];
      end else if (bst_pkg::id_sel(tf_ff.ir_cur)) begin
         dr_out = tr_ff.id_sh[0];
      end else begin
         dr_out = tr_ff.byp;
      end
   end

   // ==========================================================
   // Rising test clock: capture and shift
   always_comb begin
      nxt_tr = tr_ff;
      case (tap.state)
         bst_pkg::ST_CAP_DR: begin
            if (bst_pkg::scan_sel(tf_ff.ir_cur)) begin
               nxt_tr.bsr_sh = pin_sync;
            end else if (bst_pkg::id_sel(tf_ff.ir_cur)) begin
               nxt_tr.id_sh = id_word;
            end
         end
         bst_pkg::ST_SH_DR: begin
            if (bst_pkg::scan_sel(tf_ff.ir_cur)) begin
               nxt_tr.bsr_sh = {tdi, tr_ff.bsr_sh[bst_pkg::BSR_W-1:1]};
            end else if (bst_pkg::id_sel(tf_ff.ir_cur)) begin
               nxt_tr.id_sh = {tdi, tr_ff.id_sh[bst_pkg::ID_W-1:1]};
            end else begin
               nxt_tr.byp = tdi;
            end
         end
         bst_pkg::ST_CAP_IR: begin
            nxt_tr.ir_sh = bst_pkg::IR_CAPTURE;
         end
         bst_pkg::ST_SH_IR: begin
            nxt_tr.ir_sh = {tdi, tr_ff.ir_sh[bst_pkg::IR_W-1:1]};
         end
         default: begin
            nxt_tr = tr_ff;
         end
      endcase
   end

   always_ff @(posedge tck or posedge tck_rst) begin
      if (tck_rst) begin
         tr_ff <= bst_pkg::TR_RST;
      end else begin
         tr_ff <= nxt_tr;
      end
   end

   // ==========================================================
   // Falling test clock: output, latches and instruction
   // Output changes half a period after the shift, ahead of the tester sample
   always_comb begin
      nxt_tf = tf_ff;
      nxt_tf.tdo_oe = sh_dr || sh_ir;
      if (sh_dr) begin
         nxt_tf.tdo = dr_out;
      end else if (sh_ir) begin
         nxt_tf.tdo = tr_ff.ir_sh[0];
      end
      case (tap.state)
         bst_pkg::ST_TLR: begin
            nxt_tf.ir_cur = bst_pkg::IR_IDCODE;
         end
         bst_pkg::ST_UPD_IR: begin
            nxt_tf.ir_cur = tr_ff.ir_sh;
         end
         bst_pkg::ST_UPD_DR: begin
            if (bst_pkg::scan_sel(tf_ff.ir_cur)) begin
               nxt_tf.bsr_lat = tr_ff.bsr_sh;
               nxt_tf.upd_tgl = ~tf_ff.upd_tgl;
            end
         end
         default: begin
            nxt_tf.ir_cur = tf_ff.ir_cur;
         end
      endcase
      // Test drive only under external test
      nxt_tf.ext_on = (nxt_tf.ir_cur == bst_pkg::IR_EXTEST);
   end

   always_ff @(negedge tck or posedge tck_rst) begin
      if (tck_rst) begin
         tf_ff <= bst_pkg::TF_RST;
      end else begin
         tf_ff <= nxt_tf;
      end
   end

   // ==========================================================
   // System clock: pin multiplexer
   // Latch word is copied once its toggle has settled; a second update less
   // than four system clocks later is already taken into this copy
   always_comb begin
      nxt_sys = sys_ff;
      if (ce) begin
         nxt_sys.tap_rst_req = 1'b0;
         nxt_sys.tgl_seen = tgl_sync;
         if (tgl_sync != sys_ff.tgl_seen) begin
            nxt_sys.lat_copy = tf_ff.bsr_lat;
         end
         nxt_sys.test_mode = mode_sync;
         nxt_sys.pin_out = mode_sync ? nxt_sys.lat_copy : core_pin_out;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sys_ff <= bst_pkg::SYS_RST;
      end else begin
         sys_ff <= nxt_sys;
      end
   end

   // Outputs straight from registers
   assign tdo       = tf_ff.tdo;
   assign tdo_oe    = tf_ff.tdo_oe;
   assign pin_out   = sys_ff.pin_out;
   assign test_mode = sys_ff.test_mode;

   // ==========================================================
   // Checks
   sequence s_id_start;
      tap.state == bst_pkg::ST_CAP_DR && bst_pkg::id_sel(tf_ff.ir_cur) ##1 sh_dr;
   endsequence
   sequence s_byp_shift;
      (sh_dr && tf_ff.ir_cur == bst_pkg::IR_BYPASS) [*2];
   endsequence

   AST_ID_FIRST: assert property (@(posedge tck) disable iff (tck_rst)
                                  s_id_start |-> tf_ff.tdo == 1'b1 && tf_ff.tdo_oe)
      else $error("identity first bit not one");
   AST_BYP_DELAY: assert property (@(posedge tck) disable iff (tck_rst)
                                   s_byp_shift |-> tf_ff.tdo == $past(tdi))
      else $error("pass bit delay not one clock");
   AST_CAP_KEEP: assert property (@(posedge tck) disable iff (tck_rst)
                                  tap.state == bst_pkg::ST_CAP_DR && !bst_pkg::scan_sel(tf_ff.ir_cur)
                                  |=> $stable(tr_ff.bsr_sh))
      else $error("chain loaded without chain instruction");
   AST_LAT_UPD: assert property (@(negedge tck) disable iff (tck_rst)
                                 !$stable(tf_ff.bsr_lat) |-> $past(tap.state) == bst_pkg::ST_UPD_DR)
      else $error("latch changed outside update");
   AST_TLR_ID: assert property (@(negedge tck) disable iff (tck_rst)
                                tap.state == bst_pkg::ST_TLR |=> tf_ff.ir_cur == bst_pkg::IR_IDCODE && !tf_ff.ext_on)
      else $error("reset state did not select identity");
   AST_CAP_IR: assert property (@(posedge tck) disable iff (tck_rst)
                                tap.state == bst_pkg::ST_CAP_IR
                                |=> tr_ff.ir_sh == bst_pkg::IR_CAPTURE && $stable(tf_ff.ir_cur))
      else $error("instruction capture pattern wrong");
   AST_PAUSE_FRZ: assert property (@(posedge tck) disable iff (tck_rst)
                                   tap.state == bst_pkg::ST_PAU_DR |=> $stable(tr_ff.bsr_sh) && $stable(tr_ff.id_sh))
      else $error("register moved during pause");
   AST_PIN_NORM: assert property (@(posedge mclk) disable iff (rst)
                                  ce && !mode_sync |=> pin_out == $past(core_pin_out) && !test_mode)
      else $error("pins not in normal drive");
endmodule

// ==== verif/bst_tester.sv ====
`timescale 1ns/1ps
// ==========================================================
// Tester model: owns the link clock, samples tdo like a tester
module bst_tester (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   // Link clock stands low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // stable at rising
   // One 32 ns period; tdo read just before the rising edge
   task automatic bit_io(input logic m, input logic d, output logic q, output logic oe);
      tms = m;
      tdi = d;
      #8;
      q = tdo;
      oe = tdo_oe;
      tck = 1'b1;
      #16;
      tck = 1'b0;
      #8;
   endtask
endmodule

// ==== verif/test_boundary_scan_tap_data_registers.sv ====
`timescale 1ns/1ps
// ==========================================================
// Bench with a reference model of the scan port
module test_boundary_scan_tap_data_registers;
   localparam logic [10:0] PROD_V  = 11'h2a3;  // Arbitrary value
   localparam logic [15:0] PART_V  = 16'h5a17; // Arbitrary value
   localparam logic [3:0]  REV_V   = 4'h9;     // Arbitrary value
   localparam logic [31:0] ID_WORD = {REV_V, PART_V, PROD_V, 1'b1};
   // Controller graph, next state for tms low and high
   localparam int          NXT_LO [16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
   localparam int          NXT_HI [16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
   localparam logic [2:0]  CODES [6]   = '{3'h7, 3'h5, 3'h4, 3'h0, 3'h6, 3'h0};
   logic         mclk, rst, ce, tck, tms, tdi, tdo, tdo_oe, test_mode, tdo_s, oe_s;
   logic [97:0]  pin_in, core_pin_out, pin_out, lat_m;
   logic [127:0] w;
   logic [31:0]  rs;
   int           miscompares, samples_checked, st_m, ir_m;

   bst_tap_top #(.PRODUCER(PROD_V), .PART(PART_V), .REVISION(REV_V)) u_dut (
      .mclk(mclk), .rst(rst), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
      .pin_in(pin_in), .core_pin_out(core_pin_out), .pin_out(pin_out), .test_mode(test_mode));
   bst_tester u_tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

   // System clock, 50 ns period
   always #25 mclk = ~mclk;

   // ==========================================================
   // Helpers
   function automatic logic [127:0] rnd_w();
      for (int k = 0; k < 4; k++) begin
         rs = rs ^ (rs << 13);
         rs = rs ^ (rs >> 17);
         rs = rs ^ (rs << 5);
         rnd_w = {rnd_w[95:0], rs};
      end
   endfunction
   task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // One link edge; driver is live only in shift states
   task automatic step(input logic m, input logic d);
      u_tst.bit_io(m, d, tdo_s, oe_s);
      chk("tdo_oe", {127'h0, st_m == 4 || st_m == 11}, {127'h0, oe_s});
      st_m = m ? NXT_HI[st_m] : NXT_LO[st_m];
   endtask
   task automatic walk(input logic [7:0] pat, input int n);
      for (int k = 0; k < n; k++) begin
         step(pat[k], pat[k]);
      end
   endtask
   // Shift n bits, detouring through pause after bit p
   task automatic shift_bits(input int n, input int p, input logic [127:0] din, output logic [127:0] dout);
      dout = '0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1 || i == p - 1, din[i]);
         dout[i] = tdo_s;
         if (i == p - 1) begin
            walk(8'h04, 4);
         end
      end
   endtask
   // Pins follow the core, or the latch under external test
   task automatic check_pins();
      repeat (10) @(negedge mclk);
      chk("test_mode", {127'h0, ir_m == 0}, {127'h0, test_mode});
      chk("pin_out", {30'h0, ir_m == 0 ? lat_m : core_pin_out}, {30'h0, pin_out});
   endtask
   task automatic load_ir(input logic [2:0] code);
      logic [127:0] dout;
      walk(8'h03, 4);
      shift_bits(3, 0, {125'h0, code}, dout);
      chk("capture pattern", {125'h0, bst_pkg::IR_CAPTURE}, {125'h0, dout[2:0]});
      walk(8'h01, 2);
      ir_m = code;
   endtask
   task automatic scan_dr(input int n, input int p);
      logic [127:0] din, dout, cap;
      int           len;
      din = rnd_w();
      len = (ir_m == 0 || ir_m == 4) ? 98 : (ir_m == 6) ? 32 : 1;
      cap = (len == 98) ? {30'h0, pin_in} : {96'h0, ID_WORD};
      walk(8'h01, 3);
      shift_bits(n, p, din, dout);
      for (int i = (len == 1); i < n; i++) begin
         chk("scan bit", {127'h0, i < len ? cap[i] : din[i - len]}, {127'h0, dout[i]});
      end
      check_pins();
      walk(8'h01, 2);
      if (len == 98) begin
         lat_m = din[97:0];
      end
      check_pins();
   endtask
   task automatic go_reset();
      walk(8'h1f, 6);
      ir_m = 6;
      check_pins();
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      rs = 32'h0000_3375;
      miscompares = 0;
      samples_checked = 0;
      mclk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      w = rnd_w();
      pin_in = w[97:0];
      core_pin_out = w[127:30];
      st_m = 0;
      ir_m = 6;
      lat_m = '0;
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      #7;
      go_reset();
      scan_dr(40, 0);
      $display("test identity after reset done");
      // Clock enable low freezes the pin multiplexer
      @(negedge mclk);
      ce = 1'b0;
      core_pin_out = ~core_pin_out;
      repeat (4) @(negedge mclk);
      chk("frozen pin_out", {30'h0, ~core_pin_out}, {30'h0, pin_out});
      ce = 1'b1;
      check_pins();
      $display("test clock enable done");
      for (int c = 0; c < 6; c++) begin
         @(negedge mclk);
         w = rnd_w();
         pin_in = w[97:0];
         core_pin_out = w[127:30];
         load_ir(CODES[c]);
         check_pins();
         // Pause detour inside the frame, never on its last bit
         scan_dr((CODES[c] == 3'h0 || CODES[c] == 3'h4) ? 98 : 40, 20);
         $display("test instruction %h done", CODES[c]);
      end
      go_reset();
      $display("test mode-select reset done");
      // Mid-run reset without link clock
      @(negedge mclk);
      rst = 1'b1;
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      st_m = 0;
      lat_m = '0;
      go_reset();
      scan_dr(40, 0);
      $display("test system reset done");
      end_of_test();
   end

   // Watchdog against a hung run
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      end_of_test();
   end
endmodule
